// File: rtl/mrs_pkg.sv
package mrs_pkg;
  // ==========================================================
  // reset load values
  localparam logic [15:0] PC_RESET = 16'hfffe;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] VECTOR_HI = 16'hffff;
  localparam int NUM_IRQ = 8;
  localparam int PRESC_W = 16;
  // ==========================================================
  // warm-up timing at the 50 MHz core clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int WARMUP_NS = 20000;
  localparam int WARMUP_CYCLES = (WARMUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_W = 12;
  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_KEY = 8'h04;
  localparam logic [7:0] ADDR_IRQEN = 8'h08;
  localparam logic [7:0] ADDR_PEND = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] PIN_KEY = 8'hb2;
  // ctrl fields
  localparam int CTRL_LFOSC = 0;
  localparam int CTRL_PORTREL = 1;
  localparam int CTRL_VDET = 2;
  localparam int CTRL_PINPORT = 3;
  localparam int CTRL_DRVLVL = 4;
  localparam int CTRL_DRVEN = 5;
  localparam int CTRL_W = 6;
  // irq enable fields
  localparam int IRQEN_GIE = 8;
  localparam int IRQEN_RBS = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {MRS_HOLD, MRS_WARM, MRS_RUN} mrs_state_t;
endpackage

// File: rtl/mrs_pin_sync.sv
`timescale 1ns/1ns
// ==========================================================
// three-stage synchroniser; output moves once stages two and three agree
module mrs_pin_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic ff1_r;
  logic ff2_r;
  logic ff3_r;

  // first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ff1_r <= INIT;
      ff2_r <= INIT;
      ff3_r <= INIT;
    end else begin
      ff1_r <= asyncIn;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // filtered level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncOut <= INIT;
    end else if (ff2_r == ff3_r) begin
      syncOut <= ff3_r;
    end
  end
endmodule // mrs_pin_sync

// File: rtl/mrs_warmup_counter.sv
`timescale 1ns/1ns
// ==========================================================
// warm-up counter: cleared, counting, or stopped at its end value
module mrs_warmup_counter (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic enable,
  output logic [mrs_pkg::WARM_W-1:0] count,
  output logic done
);
  localparam logic [mrs_pkg::WARM_W-1:0] LAST = mrs_pkg::WARM_W'(mrs_pkg::WARMUP_CYCLES - 1);

  // clear wins over count; stops when the last value is reached
  always_ff @(posedge core_clk) begin
    if (rst || clear) begin
      count <= '0;
      done <= 1'b0;
    end else if (enable && !done) begin
      count <= count + 1'b1;
      done <= (count == LAST - 1'b1);
    end
  end
endmodule // mrs_warmup_counter

// File: rtl/mrs_reset_seq.sv
`timescale 1ns/1ns
// Operation
// - pc reads 0xfffe and sp 0x00ff in reset, warm-up and at its end
// - register bank select held 0 until the program runs
// - global, per-source enables and pending latches held 0 through warm-up
// - high-frequency oscillator on, low-frequency off, during reset and warm-up
// - warm-up counter cleared in reset, counts, stops; watchdog on after
// - prescaler held 0 through warm-up, port pins high-impedance through and after warm-up
// - voltage detection disabled only by power-on or pin reset
// - power-on reset below release level, reasserted below detection level
// - reset pin shared with a port, reset function selected at power-up
// - power-on and pin reset combined as an or
// - warm-up starts at the later release of both sources
// - pin low of at least 5 us resets, rising edge starts warm-up
// - cpu and peripherals released only after warm-up completes
// - any reset during warm-up restarts the counter from zero
// - cpu fetches its start from the vector at 0xfffe to 0xffff
module mrs_reset_seq (
  input wire logic core_clk,
  input wire logic rst,
  // supply comparators and shared pin, asynchronous
  input wire logic supplyAboveRelease,
  input wire logic supplyBelowDetect,
  input wire logic sharedResetPortPinIn,
  output logic sharedResetPortPinOut,
  output logic sharedResetPortPinOeN,
  // other internal reset causes, same clock
  input wire logic internalResetReq,
  input wire logic [mrs_pkg::NUM_IRQ-1:0] irqRequest,
  // core side
  output logic cpuHold,
  output logic periphHold,
  output logic vectorFetch,
  output logic [15:0] vectorAddr,
  output logic [15:0] progCounterInit,
  output logic [15:0] stackPtrInit,
  output logic reg_bank_select,
  output logic global_irq_enable,
  output logic [mrs_pkg::NUM_IRQ-1:0] source_irq_enable,
  output logic [mrs_pkg::NUM_IRQ-1:0] irq_pending_latch,
  output logic hfOscEnable,
  output logic lfOscEnable,
  output logic watchdogEnable,
  output logic [mrs_pkg::PRESC_W-1:0] prescaler,
  output logic portHiZ,
  output logic voltDetectEnable,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================
  // declarations
  mrs_pkg::mrs_state_t state_r;
  mrs_pkg::mrs_state_t state_nxt;
  logic relSync;
  logic detSync;
  logic pinSync;
  logic porActive_r;
  logic pinIsReset_r;
  logic pinResetActive;
  logic anyReset;
  logic [mrs_pkg::WARM_W-1:0] warmCount;
  logic warmDone;
  logic [mrs_pkg::CTRL_W-1:0] ctrl_r;
  logic wrFire;
  logic rdFire;
  logic wrCtrl;
  logic wrKey;
  logic wrIrqEn;
  logic wrPend;
  logic [31:0] rdValue;
  logic rdHit;

  // ==========================================================
  // pin and comparator synchronisers
  mrs_pin_sync #(.INIT(1'b0)) uRelSync (
    .core_clk(core_clk),
    .rst(rst),
    .asyncIn(supplyAboveRelease),
    .syncOut(relSync)
  );
  mrs_pin_sync #(.INIT(1'b1)) uDetSync (
    .core_clk(core_clk),
    .rst(rst),
    .asyncIn(supplyBelowDetect),
    .syncOut(detSync)
  );
  // pin starts low so no release is seen before it is sampled
  mrs_pin_sync #(.INIT(1'b0)) uPinSync (
    .core_clk(core_clk),
    .rst(rst),
    .asyncIn(sharedResetPortPinIn),
    .syncOut(pinSync)
  );

  // ==========================================================
  // power-on reset with hysteresis between the two thresholds
  always_ff @(posedge core_clk) begin
    if (rst) begin
      porActive_r <= 1'b1;
    end else if (detSync) begin
      porActive_r <= 1'b1;
    end else if (relSync) begin
      porActive_r <= 1'b0;
    end
  end

  // pin function: reset at power-up, port only after the key write
  always_ff @(posedge core_clk) begin
    if (rst || porActive_r) begin
      pinIsReset_r <= 1'b1;
    end else if (wrKey && s_axi_wdata[7:0] == mrs_pkg::PIN_KEY) begin
      pinIsReset_r <= !ctrl_r[mrs_pkg::CTRL_PINPORT];
    end
  end

  // either source holds the device; the later release starts warm-up
  assign pinResetActive = pinIsReset_r && !pinSync;
  assign anyReset = rst || porActive_r || pinResetActive || internalResetReq;

  // ==========================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mrs_pkg::MRS_HOLD: begin
        if (!anyReset) begin
          state_nxt = mrs_pkg::MRS_WARM;
        end
      end
      mrs_pkg::MRS_WARM: begin
        if (anyReset) begin
          state_nxt = mrs_pkg::MRS_HOLD;
        end else if (warmDone) begin
          state_nxt = mrs_pkg::MRS_RUN;
        end
      end
      mrs_pkg::MRS_RUN: begin
        if (anyReset) begin
          state_nxt = mrs_pkg::MRS_HOLD;
        end
      end
      default: state_nxt = mrs_pkg::MRS_HOLD;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= mrs_pkg::MRS_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // counter cleared in hold, counting in warm-up, frozen after
  mrs_warmup_counter uWarm (
    .core_clk(core_clk),
    .rst(rst),
    .clear(state_r == mrs_pkg::MRS_HOLD || anyReset),
    .enable(state_r == mrs_pkg::MRS_WARM),
    .count(warmCount),
    .done(warmDone)
  );

  // ==========================================================
  // core-side outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpuHold <= 1'b1;
      periphHold <= 1'b1;
      vectorFetch <= 1'b0;
      watchdogEnable <= 1'b0;
    end else begin
      cpuHold <= state_nxt != mrs_pkg::MRS_RUN;
      periphHold <= state_nxt != mrs_pkg::MRS_RUN;
      vectorFetch <= state_r == mrs_pkg::MRS_WARM && state_nxt == mrs_pkg::MRS_RUN;
      watchdogEnable <= state_nxt == mrs_pkg::MRS_RUN;
    end
  end

  // load values are constant; the core takes them while held
  always_ff @(posedge core_clk) begin
    progCounterInit <= mrs_pkg::PC_RESET;
    stackPtrInit <= mrs_pkg::SP_RESET;
    vectorAddr <= mrs_pkg::PC_RESET;
    hfOscEnable <= 1'b1;
  end

  // low-frequency oscillator only by software once running
  always_ff @(posedge core_clk) begin
    if (rst || state_nxt != mrs_pkg::MRS_RUN) begin
      lfOscEnable <= 1'b0;
    end else begin
      lfOscEnable <= ctrl_r[mrs_pkg::CTRL_LFOSC];
    end
  end

  // prescaler runs free only after warm-up
  always_ff @(posedge core_clk) begin
    if (rst || state_nxt != mrs_pkg::MRS_RUN) begin
      prescaler <= '0;
    end else begin
      prescaler <= prescaler + 1'b1;
    end
  end

  // ports stay floating until software releases them
  always_ff @(posedge core_clk) begin
    if (rst || state_nxt != mrs_pkg::MRS_RUN) begin
      portHiZ <= 1'b1;
    end else begin
      portHiZ <= !ctrl_r[mrs_pkg::CTRL_PORTREL];
    end
  end

  // pin as port: driven only when port mode, released and enabled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sharedResetPortPinOut <= 1'b1;
      sharedResetPortPinOeN <= 1'b1;
    end else begin
      sharedResetPortPinOut <= ctrl_r[mrs_pkg::CTRL_DRVLVL];
      sharedResetPortPinOeN <= pinIsReset_r || state_nxt != mrs_pkg::MRS_RUN ||
                               !ctrl_r[mrs_pkg::CTRL_PORTREL] || !ctrl_r[mrs_pkg::CTRL_DRVEN];
    end
  end

  // voltage detection survives internal resets
  always_ff @(posedge core_clk) begin
    if (rst || porActive_r || pinResetActive) begin
      voltDetectEnable <= 1'b0;
    end else if (wrCtrl && s_axi_wstrb[0]) begin
      voltDetectEnable <= s_axi_wdata[mrs_pkg::CTRL_VDET];
    end
  end

  // ==========================================================
  // interrupt state, forced clear whenever not running
  always_ff @(posedge core_clk) begin
    if (rst || state_nxt != mrs_pkg::MRS_RUN) begin
      global_irq_enable <= 1'b0;
      source_irq_enable <= '0;
      reg_bank_select <= 1'b0;
    end else if (wrIrqEn) begin
      global_irq_enable <= s_axi_wdata[mrs_pkg::IRQEN_GIE];
      source_irq_enable <= s_axi_wdata[mrs_pkg::NUM_IRQ-1:0];
      reg_bank_select <= s_axi_wdata[mrs_pkg::IRQEN_RBS];
    end
  end

  // pending latches: a request wins over a same-cycle clear
  for (genvar i = 0; i < mrs_pkg::NUM_IRQ; i++) begin : gPend
    always_ff @(posedge core_clk) begin
      if (rst || state_nxt != mrs_pkg::MRS_RUN) begin
        irq_pending_latch[i] <= 1'b0;
      end else if (irqRequest[i]) begin
        irq_pending_latch[i] <= 1'b1;
      end else if (wrPend && s_axi_wdata[i]) begin
        irq_pending_latch[i] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite slave, one write and one read at a time
  assign wrFire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign rdFire = s_axi_arready && s_axi_arvalid;
  assign wrCtrl = wrFire && s_axi_awaddr == mrs_pkg::ADDR_CTRL;
  assign wrKey = wrFire && s_axi_awaddr == mrs_pkg::ADDR_KEY && s_axi_wstrb[0];
  assign wrIrqEn = wrFire && s_axi_awaddr == mrs_pkg::ADDR_IRQEN && s_axi_wstrb[1:0] == 2'h3;
  assign wrPend = wrFire && s_axi_awaddr == mrs_pkg::ADDR_PEND && s_axi_wstrb[0];

  // address and data taken together in one cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mrs_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (s_axi_awaddr == mrs_pkg::ADDR_CTRL || s_axi_awaddr == mrs_pkg::ADDR_KEY ||
                        s_axi_awaddr == mrs_pkg::ADDR_IRQEN || s_axi_awaddr == mrs_pkg::ADDR_PEND)
                       ? mrs_pkg::RESP_OKAY : mrs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control bits cleared by every reset cause
  always_ff @(posedge core_clk) begin
    if (anyReset) begin
      ctrl_r <= '0;
    end else if (wrCtrl && s_axi_wstrb[0]) begin
      ctrl_r <= s_axi_wdata[mrs_pkg::CTRL_W-1:0];
    end
  end

  // read mux; status shows the sequencer's own state
  always_comb begin
    rdHit = 1'b1;
    rdValue = '0;
    case (s_axi_araddr)
      mrs_pkg::ADDR_CTRL: rdValue = {26'h0, ctrl_r[5:3], voltDetectEnable, ctrl_r[1:0]};
      mrs_pkg::ADDR_KEY: rdValue = {31'h0, pinIsReset_r};
      mrs_pkg::ADDR_IRQEN: rdValue = {22'h0, reg_bank_select, global_irq_enable, source_irq_enable};
      mrs_pkg::ADDR_PEND: rdValue = {24'h0, irq_pending_latch};
      mrs_pkg::ADDR_STAT: rdValue = {prescaler, 10'h0, watchdogEnable, porActive_r, pinSync,
                                     1'b0, state_r};
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= mrs_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdValue;
        s_axi_rresp <= rdHit ? mrs_pkg::RESP_OKAY : mrs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  sequence sWarmStart;
    state_r == mrs_pkg::MRS_HOLD && !anyReset;
  endsequence
  sequence sWarmEnd;
    state_r == mrs_pkg::MRS_WARM && warmDone && !anyReset;
  endsequence

  a_pc_sp_hold: assert property (@(posedge core_clk) disable iff (rst)
    cpuHold |-> progCounterInit == mrs_pkg::PC_RESET && stackPtrInit == mrs_pkg::SP_RESET)
    else $error("pc or sp load value wrong");
  a_bank_zero: assert property (@(posedge core_clk) disable iff (rst)
    cpuHold |-> !reg_bank_select)
    else $error("bank select not zero while held");
  a_irq_cleared: assert property (@(posedge core_clk) disable iff (rst)
    cpuHold |-> !global_irq_enable && source_irq_enable == '0 && irq_pending_latch == '0)
    else $error("interrupt state not clear while held");
  a_osc_held: assert property (@(posedge core_clk) disable iff (rst)
    cpuHold |-> hfOscEnable && !lfOscEnable)
    else $error("oscillator enables wrong while held");
  a_warm_count: assert property (@(posedge core_clk) disable iff (rst)
    sWarmStart ##1 (state_r == mrs_pkg::MRS_WARM && !anyReset)[*3] |->
      warmCount == 12'h002 && !watchdogEnable)
    else $error("warm-up counter not counting");
  a_warm_finish: assert property (@(posedge core_clk) disable iff (rst)
    sWarmEnd |=> !cpuHold && watchdogEnable && vectorFetch ##1 !vectorFetch)
    else $error("release after warm-up wrong");
  a_ports_hiz: assert property (@(posedge core_clk) disable iff (rst)
    cpuHold |-> portHiZ && sharedResetPortPinOeN && prescaler == '0)
    else $error("ports or prescaler active while held");
  a_vdet_kept: assert property (@(posedge core_clk) disable iff (rst)
    internalResetReq && !porActive_r && !pinResetActive && !wrCtrl |=>
      $stable(voltDetectEnable))
    else $error("internal reset changed voltage detect");
  a_por_hyst: assert property (@(posedge core_clk) disable iff (rst)
    detSync |=> porActive_r ##1 cpuHold)
    else $error("power-on reset not asserted");
  a_reset_or: assert property (@(posedge core_clk) disable iff (rst)
    (porActive_r || pinResetActive) |=> state_r == mrs_pkg::MRS_HOLD && warmCount == '0)
    else $error("reset source did not hold device");
  a_warm_restart: assert property (@(posedge core_clk) disable iff (rst)
    state_r == mrs_pkg::MRS_WARM && anyReset |=> state_r == mrs_pkg::MRS_HOLD && warmCount == '0)
    else $error("warm-up not restarted");
endmodule // mrs_reset_seq

// File: tb/mrs_board_reset.sv
`timescale 1ns/1ns
// ==========================================================
// board side: supply comparators and an open-drain reset source
module mrs_board_reset #(
  parameter int RISE_CYC = 40,
  parameter int HOLD_CYC = 250
) (
  input wire logic core_clk,
  input wire logic supplyOn,
  input wire logic slowRise,
  input wire logic pulseReq,
  output logic supplyAboveRelease,
  output logic supplyBelowDetect,
  output logic boardPinLow
);
  int riseCnt = 0;
  int lowCnt = 0;
  // supply ramps up over RISE_CYC cycles, drops at once
  always @(posedge core_clk) begin
    if (!supplyOn) begin
      riseCnt <= 0;
    end else if (riseCnt < RISE_CYC) begin
      riseCnt <= riseCnt + 1;
    end
  end
  assign supplyAboveRelease = supplyOn && (riseCnt >= RISE_CYC / 2);
  assign supplyBelowDetect = !supplyOn;
  // slow ramp: pin low until stable plus 5 us; fast ramp leaves it high
  always @(posedge core_clk) begin
    if (!supplyOn && slowRise) begin
      lowCnt <= RISE_CYC + HOLD_CYC;
    end else if (pulseReq) begin
      lowCnt <= HOLD_CYC;
    end else if (lowCnt > 0) begin
      lowCnt <= lowCnt - 1;
    end
  end
  assign boardPinLow = lowCnt > 0;
endmodule // mrs_board_reset

// File: tb/mcu_reset_sequencer_tb_top.sv
`timescale 1ns/1ns
// ==========================================================
// bench top: board model on supply and pin, bench on the bus
module mcu_reset_sequencer_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic supplyOn = 1'b0, slowRise = 1'b1, pulseReq = 1'b0, internalResetReq = 1'b0;
  logic supplyAboveRelease, supplyBelowDetect, boardPinLow, sharedResetPortPinIn;
  logic sharedResetPortPinOut, sharedResetPortPinOeN, cpuHold, periphHold, vectorFetch;
  logic reg_bank_select, global_irq_enable, hfOscEnable, lfOscEnable, watchdogEnable;
  logic portHiZ, voltDetectEnable;
  logic [7:0] irqRequest = 8'h00;
  logic [7:0] source_irq_enable, irq_pending_latch;
  logic [15:0] vectorAddr, progCounterInit, stackPtrInit, prescaler;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] rd;
  logic [1:0] rsp;
  int num_errors = 0;
  int checks_done = 0;
  int n;
  localparam int W = mrs_pkg::WARMUP_CYCLES;
  always #10 core_clk = ~core_clk;
  // pull-up on the pin; board pulls low, port drives only when enabled
  assign sharedResetPortPinIn = boardPinLow ? 1'b0
                              : (sharedResetPortPinOeN ? 1'b1 : sharedResetPortPinOut);
  mrs_board_reset i_board (.core_clk, .supplyOn, .slowRise, .pulseReq,
    .supplyAboveRelease, .supplyBelowDetect, .boardPinLow);
  mrs_reset_seq i_dut (.core_clk, .rst, .supplyAboveRelease, .supplyBelowDetect,
    .sharedResetPortPinIn, .sharedResetPortPinOut, .sharedResetPortPinOeN,
    .internalResetReq, .irqRequest, .cpuHold, .periphHold, .vectorFetch, .vectorAddr,
    .progCounterInit, .stackPtrInit, .reg_bank_select, .global_irq_enable,
    .source_irq_enable, .irq_pending_latch, .hfOscEnable, .lfOscEnable, .watchdogEnable,
    .prescaler, .portHiZ, .voltDetectEnable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ==========================================================
  // checking and closing
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic timeout(input string what);
    num_errors++;
    $display("[FAIL] %s expected answer seen none", what);
    finish_test();
  endtask
  // ==========================================================
  // bus master: valids held until each ready, ready held until answer
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        s_axi_wstrb <= 4'h0;
        break;
      end
    end
    if (k == 50) timeout("write");
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (k == 50) timeout("read");
  endtask
  // ==========================================================
  // held state, the same in reset and in warm-up
  task automatic chk_held();
    chk("pc", mrs_pkg::PC_RESET, progCounterInit);
    chk("sp", mrs_pkg::SP_RESET, stackPtrInit);
    chk("bank", 1'b0, reg_bank_select);
    chk("gie", 1'b0, global_irq_enable);
    chk("src en", 8'h00, source_irq_enable);
    chk("pending", 8'h00, irq_pending_latch);
    chk("hf osc", 1'b1, hfOscEnable);
    chk("lf osc", 1'b0, lfOscEnable);
    chk("wdog", 1'b0, watchdogEnable);
    chk("presc", 16'h0000, prescaler);
    chk("hiz", 1'b1, portHiZ);
    chk("periph", 1'b1, periphHold);
  endtask
  // counts held cycles once both sources released; irqs offered mid warm-up
  task automatic run_warm(input bit kick, input bit again);
    int k;
    bit seen;
    n = 0;
    seen = 0;
    for (k = 0; k < 6000; k++) begin
      @(posedge core_clk);
      internalResetReq <= (kick && k == 0) || (again && n == 500);
      irqRequest <= (n > 400 && n < 600) ? 8'hff : 8'h00;
      #1;
      if (internalResetReq) begin
        n = 0;
        if (k > 0) again = 0;
      end
      if (supplyAboveRelease && !boardPinLow && cpuHold === 1'b1) n++;
      if (n == 500) chk_held();
      if (cpuHold === 1'b1) seen = 1;
      if (seen && cpuHold === 1'b0) break;
    end
    if (k == 6000) timeout("release");
    chk("warm len", 1'b1, n >= W && n <= W + 10);
    chk("fetch", 1'b1, vectorFetch);
    chk("vector", mrs_pkg::PC_RESET, vectorAddr);
    chk("pc end", mrs_pkg::PC_RESET, progCounterInit);
    chk("sp end", mrs_pkg::SP_RESET, stackPtrInit);
    chk("wdog end", 1'b1, watchdogEnable);
    chk("hiz end", 1'b1, portHiZ);
    chk("periph end", 1'b0, periphHold);
    @(posedge core_clk);
    #1;
    chk("fetch once", 1'b0, vectorFetch);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_power_up();
    #1;
    chk("cpu held", 1'b1, cpuHold);
    chk_held();
    @(posedge core_clk);
    supplyOn <= 1'b1;
    run_warm(0, 0);
    $display("test power_up done");
  endtask
  task automatic t_bus();
    axi_read(mrs_pkg::ADDR_STAT, rd, rsp);
    chk("stat", 32'h22, rd & 32'h23);
    axi_read(mrs_pkg::ADDR_KEY, rd, rsp);
    chk("pin is reset", 32'h1, rd & 32'h1);
    axi_read(8'h40, rd, rsp);
    chk("unmapped resp", mrs_pkg::RESP_SLVERR, rsp);
    chk("unmapped data", 32'h0, rd);
    axi_write(mrs_pkg::ADDR_IRQEN, 32'h3ff, rsp);
    chk("irqen resp", mrs_pkg::RESP_OKAY, rsp);
    chk("en out", 32'h3ff, {reg_bank_select, global_irq_enable, source_irq_enable});
    @(posedge core_clk);
    irqRequest <= 8'h05;
    @(posedge core_clk);
    irqRequest <= 8'h00;
    axi_read(mrs_pkg::ADDR_PEND, rd, rsp);
    chk("pend set", 32'h05, rd);
    axi_write(mrs_pkg::ADDR_PEND, 32'h05, rsp);
    axi_read(mrs_pkg::ADDR_PEND, rd, rsp);
    chk("pend clr", 32'h00, rd);
    // pin as port driving low must not reset the device
    axi_write(mrs_pkg::ADDR_CTRL, 32'h2f, rsp);
    axi_write(mrs_pkg::ADDR_KEY, {24'h0, mrs_pkg::PIN_KEY}, rsp);
    repeat (8) @(posedge core_clk);
    #1;
    chk("vdet on", 1'b1, voltDetectEnable);
    chk("lf osc run", 1'b1, lfOscEnable);
    chk("hiz run", 1'b0, portHiZ);
    chk("presc run", 1'b1, prescaler != 16'h0000);
    chk("port drive", 2'h0, {sharedResetPortPinOeN, sharedResetPortPinOut});
    chk("port no rst", 1'b0, cpuHold);
    // release the pin and let the synchroniser see it high before reset mode returns
    axi_write(mrs_pkg::ADDR_CTRL, 32'h04, rsp);
    repeat (6) @(posedge core_clk);
    axi_write(mrs_pkg::ADDR_KEY, {24'h0, mrs_pkg::PIN_KEY}, rsp);
    axi_read(mrs_pkg::ADDR_KEY, rd, rsp);
    chk("pin back", 32'h1, rd);
    $display("test bus done");
  endtask
  task automatic t_internal();
    run_warm(1, 1);
    chk("vdet kept", 1'b1, voltDetectEnable);
    $display("test internal done");
  endtask
  task automatic t_pin();
    @(posedge core_clk);
    pulseReq <= 1'b1;
    @(posedge core_clk);
    pulseReq <= 1'b0;
    run_warm(0, 0);
    chk("vdet off", 1'b0, voltDetectEnable);
    $display("test pin done");
  endtask
  task automatic t_power_down();
    @(posedge core_clk);
    supplyOn <= 1'b0;
    slowRise <= 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    chk("held low vdd", 1'b1, cpuHold);
    @(posedge core_clk);
    supplyOn <= 1'b1;
    run_warm(0, 0);
    $display("test power_down done");
  endtask
  // reset for two cycles, then the scenarios in turn
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_power_up();
    t_bus();
    t_internal();
    t_pin();
    t_power_down();
    finish_test();
  end
endmodule // mcu_reset_sequencer_tb_top
